//--- core/bcd_defines.vh
/*
 * Constants for the six-step commutation decoder: register map,
 * field positions, reset values and oscillator timing.
 * Assumes it is included by bare name from the core/ design files.
 */
// Overview of operation
// - Three sensor bits: eight codes, six valid
// - Each valid code is one 60 degree step
// - Phasing select high 60, low 120 degree
// - Direction swaps upper and lower drive phases
// - Drives sequence while output enable is high
// - Enable low: uppers off, lowers low, coast
// - Over-current ends conduction until next cycle
// - Invalid sensor code turns every drive off
// - Upper drive outputs are active low
// - At most one conduction pulse per cycle
// - Pulse width chopping only on lower drives
`ifndef BCD_DEFINES_VH
`define BCD_DEFINES_VH

// Register word indexes on the plain register port
`define BCD_ADDR_CTRL 2'h0
`define BCD_ADDR_PERIOD 2'h1
`define BCD_ADDR_DUTY 2'h2
`define BCD_ADDR_STATUS 2'h3

// Control register fields
`define BCD_CTRL_RUN_BIT 0
`define BCD_CTRL_RST 16'h0001

// Oscillator timing: 250 MHz clock, 25 kHz cycle = 10000 clocks
`define BCD_CLK_MHZ 250
`define BCD_OSC_KHZ 25
`define BCD_PERIOD_RST 16'h270F
`define BCD_DUTY_RST 16'h1388

// Status register field positions
`define BCD_ST_CODE_LSB 0
`define BCD_ST_VALID_BIT 3
`define BCD_ST_CUR_BIT 4
`define BCD_ST_PWM_BIT 5
`define BCD_ST_OCP_BIT 6
`define BCD_ST_STEP_LSB 8

// Phase step encodings (upper phase, lower phase pairs)
`define BCD_PH_A 3'h1
`define BCD_PH_B 3'h2
`define BCD_PH_C 3'h4
`define BCD_PH_NONE 3'h0
`define BCD_STEP_BAD 3'h7

`endif

//--- core/bcd_lookup.v
/*
 * Combinational commutation lookup: sensor code, phasing select and
 * direction to one-hot upper and lower phase selects.
 * Assumes sensor inputs are already synchronous to the block clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bcd_defines.vh"

module bcd_lookup (
    // Sensor code and mode
    input wire [2:0] code_in,
    input wire sel60_in,
    input wire fwd_in,
    // Decoded step
    output reg valid_out,
    output reg [2:0] step_out,
    output reg [2:0] upper_out,
    output reg [2:0] lower_out
);

    ////////////////////////////////////////////////////////////////////
    // Code to step index, per phasing convention
    ////////////////////////////////////////////////////////////////////
    reg [2:0] step; // Step 0..5, or bad
    reg [2:0] up_ph; // Forward upper phase
    reg [2:0] lo_ph; // Forward lower phase

    // Code order is {sensor a, sensor b, sensor c}
    always @* begin
        step = `BCD_STEP_BAD;
        case (code_in)
            3'h4: step = 3'h0;
            3'h6: step = 3'h1;
            3'h3: step = 3'h3;
            3'h1: step = 3'h4;
            3'h7: step = sel60_in ? 3'h2 : `BCD_STEP_BAD;
            3'h0: step = sel60_in ? 3'h5 : `BCD_STEP_BAD;
            3'h2: step = sel60_in ? `BCD_STEP_BAD : 3'h2;
            3'h5: step = sel60_in ? `BCD_STEP_BAD : 3'h5;
            default: step = `BCD_STEP_BAD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Step to phase pair, direction swap
    ////////////////////////////////////////////////////////////////////
    always @* begin
        up_ph = `BCD_PH_NONE;
        lo_ph = `BCD_PH_NONE;
        case (step)
            3'h0: begin
                up_ph = `BCD_PH_A;
                lo_ph = `BCD_PH_C;
            end
            3'h1: begin
                up_ph = `BCD_PH_B;
                lo_ph = `BCD_PH_C;
            end
            3'h2: begin
                up_ph = `BCD_PH_B;
                lo_ph = `BCD_PH_A;
            end
            3'h3: begin
                up_ph = `BCD_PH_C;
                lo_ph = `BCD_PH_A;
            end
            3'h4: begin
                up_ph = `BCD_PH_C;
                lo_ph = `BCD_PH_B;
            end
            3'h5: begin
                up_ph = `BCD_PH_A;
                lo_ph = `BCD_PH_B;
            end
            default: begin
                up_ph = `BCD_PH_NONE;
                lo_ph = `BCD_PH_NONE;
            end
        endcase
        valid_out = (step != `BCD_STEP_BAD);
        step_out = step;
        // Reverse exchanges same-letter upper and lower drives
        if (fwd_in) begin
            upper_out = up_ph;
            lower_out = lo_ph;
        end else begin
            upper_out = lo_ph;
            lower_out = up_ph;
        end
    end

endmodule
`default_nettype wire

//--- core/bcd_top.v
/*
 * Six-step commutation decoder top: oscillator cycle counter,
 * dual-latch pulse width and current-limit gating, registered drive
 * outputs and a small register port.
 * Assumes all inputs are synchronous to ref_clk_in; the board pulls
 * the output enable pin up when left open; the over-current input is
 * the digital result of an external current comparator.
 */
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "bcd_defines.vh"

module bcd_top #(
    parameter CNT_W = 16 // Oscillator counter width
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_n_in,
    // Position sensors
    input wire pos_sensor_a_in,
    input wire pos_sensor_b_in,
    input wire pos_sensor_c_in,
    // Mode pins
    input wire fwd_in,
    input wire sel60_in,
    input wire out_enable_in,
    input wire over_current_in,
    // Register port
    input wire [1:0] reg_addr_in,
    input wire [15:0] reg_wdata_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    output reg [15:0] reg_rdata_out,
    // Upper drives, active low
    output reg upper_drive_a_out,
    output reg upper_drive_b_out,
    output reg upper_drive_c_out,
    // Lower drives, active high
    output reg lower_drive_a_out,
    output reg lower_drive_b_out,
    output reg lower_drive_c_out,
    // Oscillator cycle strobe
    output reg osc_strobe_out
);

    ////////////////////////////////////////////////////////////////////
    // Reset release synchroniser
    ////////////////////////////////////////////////////////////////////
    reg rst_meta_r; // First stage, read only by second
    reg rst_sync_n_r; // Released reset used by the design

    // Assert at once, release after two edges
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_r <= 1'b0;
            rst_sync_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers written by software
    ////////////////////////////////////////////////////////////////////
    reg [15:0] ctrl_r; // Run allow bit
    reg [CNT_W-1:0] period_r; // Cycle length minus one
    reg [CNT_W-1:0] duty_r; // Lower drive on-count minus one
    reg ocp_seen_r; // Sticky over-current event
    wire ocp_clr; // Software clear of sticky bit

    assign ocp_clr = reg_wr_in && (reg_addr_in == `BCD_ADDR_STATUS)
        && reg_wdata_in[`BCD_ST_OCP_BIT];

    // Register writes
    always @(posedge ref_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            ctrl_r <= `BCD_CTRL_RST;
            period_r <= `BCD_PERIOD_RST;
            duty_r <= `BCD_DUTY_RST;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `BCD_ADDR_CTRL: ctrl_r <= reg_wdata_in;
                `BCD_ADDR_PERIOD: period_r <= reg_wdata_in[CNT_W-1:0];
                `BCD_ADDR_DUTY: duty_r <= reg_wdata_in[CNT_W-1:0];
                default: ctrl_r <= ctrl_r; // Status takes clears only
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oscillator cycle counter
    ////////////////////////////////////////////////////////////////////
    reg [CNT_W-1:0] cnt_r; // Position in the cycle
    wire osc_stb; // Last count of the cycle

    // Programmable period: strobe once every period_r+1 clocks
    assign osc_stb = (cnt_r >= period_r);

    // Counter wraps on the strobe
    always @(posedge ref_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            cnt_r <= {CNT_W{1'b0}};
        end else if (osc_stb) begin
            cnt_r <= {CNT_W{1'b0}};
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Dual latches: pulse width and current limit
    ////////////////////////////////////////////////////////////////////
    reg pwm_latch_r; // Lower drives may conduct
    reg cur_latch_r; // All drives may conduct
    reg pwm_latch_nxt;
    reg cur_latch_nxt;

    // Latches set only at the strobe, so one pulse per cycle
    always @* begin
        pwm_latch_nxt = pwm_latch_r;
        cur_latch_nxt = cur_latch_r;
        if (osc_stb) begin
            pwm_latch_nxt = 1'b1;
            cur_latch_nxt = 1'b1;
        end else if (cnt_r >= duty_r) begin
            pwm_latch_nxt = 1'b0; // Duty reached, ends the pulse
        end
        // Over-current wins even against the strobe
        if (over_current_in) begin
            cur_latch_nxt = 1'b0;
        end
    end

    // Latch flops, cleared by reset
    always @(posedge ref_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            pwm_latch_r <= 1'b0;
            cur_latch_r <= 1'b0;
        end else begin
            pwm_latch_r <= pwm_latch_nxt;
            cur_latch_r <= cur_latch_nxt;
        end
    end

    // Sticky over-current flag, event wins over clear
    always @(posedge ref_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            ocp_seen_r <= 1'b0;
        end else if (over_current_in) begin
            ocp_seen_r <= 1'b1;
        end else if (ocp_clr) begin
            ocp_seen_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Commutation lookup
    ////////////////////////////////////////////////////////////////////
    wire [2:0] code; // {a, b, c}
    wire code_valid; // Code is one of the six
    wire [2:0] step; // Step index
    wire [2:0] up_sel; // One-hot upper phase
    wire [2:0] lo_sel; // One-hot lower phase

    assign code = {pos_sensor_a_in, pos_sensor_b_in, pos_sensor_c_in};

    bcd_lookup u_lookup (
        .code_in (code),
        .sel60_in (sel60_in),
        .fwd_in (fwd_in),
        .valid_out (code_valid),
        .step_out (step),
        .upper_out (up_sel),
        .lower_out (lo_sel)
    );

    ////////////////////////////////////////////////////////////////////
    // Drive gating
    ////////////////////////////////////////////////////////////////////
    wire run; // Enabled, allowed and valid
    wire up_go; // Upper conduction allowed
    wire lo_go; // Lower conduction allowed
    wire [2:0] up_on; // Upper switches on
    wire [2:0] lo_on; // Lower switches on

    // Enable pin high runs; low coasts with every drive off
    assign run = out_enable_in && ctrl_r[`BCD_CTRL_RUN_BIT]
        && code_valid;
    assign up_go = run && cur_latch_r;
    assign lo_go = run && cur_latch_r && pwm_latch_r;
    assign up_on = up_sel & {3{up_go}};
    assign lo_on = lo_sel & {3{lo_go}};

    ////////////////////////////////////////////////////////////////////
    // Output flops
    ////////////////////////////////////////////////////////////////////
    // Uppers idle high (off), lowers idle low
    always @(posedge ref_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            upper_drive_a_out <= 1'b1;
            upper_drive_b_out <= 1'b1;
            upper_drive_c_out <= 1'b1;
            lower_drive_a_out <= 1'b0;
            lower_drive_b_out <= 1'b0;
            lower_drive_c_out <= 1'b0;
            osc_strobe_out <= 1'b0;
        end else begin
            upper_drive_a_out <= ~up_on[0];
            upper_drive_b_out <= ~up_on[1];
            upper_drive_c_out <= ~up_on[2];
            lower_drive_a_out <= lo_on[0];
            lower_drive_b_out <= lo_on[1];
            lower_drive_c_out <= lo_on[2];
            osc_strobe_out <= osc_stb;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register read port
    ////////////////////////////////////////////////////////////////////
    reg [15:0] rd_nxt; // Read mux

    // Status shows sensor code, latches and step
    always @* begin
        rd_nxt = 16'h0000;
        case (reg_addr_in)
            `BCD_ADDR_CTRL: rd_nxt = ctrl_r;
            `BCD_ADDR_PERIOD: rd_nxt[CNT_W-1:0] = period_r;
            `BCD_ADDR_DUTY: rd_nxt[CNT_W-1:0] = duty_r;
            `BCD_ADDR_STATUS: begin
                rd_nxt[`BCD_ST_CODE_LSB+2:`BCD_ST_CODE_LSB] = code;
                rd_nxt[`BCD_ST_VALID_BIT] = code_valid;
                rd_nxt[`BCD_ST_CUR_BIT] = cur_latch_r;
                rd_nxt[`BCD_ST_PWM_BIT] = pwm_latch_r;
                rd_nxt[`BCD_ST_OCP_BIT] = ocp_seen_r;
                rd_nxt[`BCD_ST_STEP_LSB+2:`BCD_ST_STEP_LSB] = step;
            end
            default: rd_nxt = 16'h0000;
        endcase
    end

    // Read data stands one cycle after the strobe only
    always @(posedge ref_clk_in or negedge rst_sync_n_r) begin
        if (!rst_sync_n_r) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= rd_nxt;
        end else begin
            reg_rdata_out <= 16'h0000;
        end
    end

endmodule
`default_nettype wire

//--- tb/bcd_sva.sv
/* Drive checker for bcd_top.
   Assumes binding onto bcd_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module bcd_sva #(
    parameter CNT_W = 16 // Oscillator counter width
) (
    // Clock and reset
    input wire ref_clk_in,
    input wire rst_n_in,
    // Inputs
    input wire pos_sensor_a_in,
    input wire pos_sensor_b_in,
    input wire pos_sensor_c_in,
    input wire fwd_in,
    input wire sel60_in,
    input wire out_enable_in,
    input wire over_current_in,
    input wire reg_wr_in,
    // Drives and strobe
    input wire upper_drive_a_out,
    input wire upper_drive_b_out,
    input wire upper_drive_c_out,
    input wire lower_drive_a_out,
    input wire lower_drive_b_out,
    input wire lower_drive_c_out,
    input wire osc_strobe_out
);
    // Switch-on flags A B C, uppers inverted
    wire [2:0] up_on = ~{upper_drive_a_out, upper_drive_b_out, upper_drive_c_out};
    wire [2:0] lo_on = {lower_drive_a_out, lower_drive_b_out, lower_drive_c_out};
    wire [2:0] code = {pos_sensor_a_in, pos_sensor_b_in, pos_sensor_c_in};
    wire bad = sel60_in ? (code == 3'h5 || code == 3'h2) : (code == 3'h7 || code == 3'h0);
    wire all_off = (up_on == 3'h0) && (lo_on == 3'h0);
    wire [5:0] in_v = {code, fwd_in, sel60_in, out_enable_in};
    reg [5:0] in_r; // Last sampled inputs
    reg [1:0] calm_r; // Quiet cycles, saturates at 3
    ////////////////////////////////////////////////////////////
    // Count cycles without input changes, current hits or writes
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            in_r <= 6'h00;
            calm_r <= 2'h0;
        end else begin
            in_r <= in_v;
            if (in_v != in_r || over_current_in || reg_wr_in) begin
                calm_r <= 2'h0;
            end else if (calm_r != 2'h3) begin
                calm_r <= calm_r + 2'h1;
            end
        end
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_hit;
        over_current_in;
    endsequence
    sequence s_dark;
        all_off;
    endsequence
    chk_upper_one_on: assert property ($onehot0(up_on))
        else $error("more than one upper drive on");
    chk_lower_one_on: assert property ($onehot0(lo_on))
        else $error("more than one lower drive on");
    chk_leg_no_short: assert property ((up_on & lo_on) == 3'h0)
        else $error("upper and lower on in one phase");
    chk_coast_all_off: assert property (!out_enable_in |=> all_off)
        else $error("drives on while enable low");
    chk_bad_code_off: assert property (bad |=> all_off)
        else $error("drives on for invalid code");
    chk_current_cut: assert property (s_hit |-> ##2 s_dark)
        else $error("drives on after over-current");
    chk_strobe_gap: assert property (osc_strobe_out |=> !osc_strobe_out [*8])
        else $error("oscillator strobe too close");
    chk_upper_no_chop: assert property ($fell(|lo_on) && calm_r == 2'h3 |-> $stable(up_on))
        else $error("upper drive moved with pulse end");
endmodule
bind bcd_top bcd_sva #(.CNT_W(CNT_W)) u_sva (
    .ref_clk_in, .rst_n_in, .pos_sensor_a_in, .pos_sensor_b_in, .pos_sensor_c_in,
    .fwd_in, .sel60_in, .out_enable_in, .over_current_in, .reg_wr_in,
    .upper_drive_a_out, .upper_drive_b_out, .upper_drive_c_out,
    .lower_drive_a_out, .lower_drive_b_out, .lower_drive_c_out, .osc_strobe_out
);
`default_nettype wire

//--- tb/bcd_partner.sv
/* Hall sensors and switch bridge model.
   Assumes drive lines of bcd_top, uppers active low. */
`timescale 1ns/1ps
`default_nettype none
module bcd_partner (
    // Clock and rotor code
    input wire logic ref_clk_in,
    input wire logic [2:0] code_in,
    // Drives, A B C
    input wire logic [2:0] upper_n_in,
    input wire logic [2:0] lower_in,
    // Sensor lines and leg short flag
    output logic pos_sensor_a_out,
    output logic pos_sensor_b_out,
    output logic pos_sensor_c_out,
    output logic shoot_out
);
    // Three sensor lines follow the rotor code
    assign {pos_sensor_a_out, pos_sensor_b_out, pos_sensor_c_out} = code_in;
    logic short_r = 1'b0; // Latched leg short, single driver
    assign shoot_out = short_r;
    // Low upper line closes the switch; both in one leg short it
    always @(posedge ref_clk_in) begin
        if ((~upper_n_in & lower_in) != 3'h0) begin
            short_r <= 1'b1;
        end
    end
endmodule
`default_nettype wire

//--- tb/bcd_top_test.sv
/* Bench for bcd_top: step table, coast, pulse width, current cut.
   Assumes bcd_partner and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module bcd_top_test;
    localparam [2:0] PA = 3'h4, PB = 3'h2, PC = 3'h1;
    localparam [17:0] UP_T = {PA, PC, PC, PB, PB, PA}; // Step 5 to 0
    localparam [17:0] LO_T = {PB, PB, PA, PA, PC, PC};
    logic clk = 1'b0, rst_n = 1'b0, fwd = 1'b1, s60 = 1'b1, en = 1'b1, oc = 1'b0;
    logic wr = 1'b0, rd = 1'b0;
    logic [2:0] code = 3'h4;
    logic [1:0] addr = 2'h0;
    logic [15:0] wdata = 16'h0000, got, dv;
    logic [31:0] seed = 32'h00016925; // 92453
    wire [15:0] rdata;
    wire ua, ub, uc, la, lb, lc, stb, sa, sb, sc, shoot;
    wire [5:0] drv = {~ua, ~ub, ~uc, la, lb, lc};
    int failures = 0, n_checks = 0, cnt_u, cnt_l;
    always #2 clk = ~clk;
    bcd_partner u_far (.ref_clk_in(clk), .code_in(code), .upper_n_in({ua, ub, uc}),
        .lower_in({la, lb, lc}), .pos_sensor_a_out(sa), .pos_sensor_b_out(sb),
        .pos_sensor_c_out(sc), .shoot_out(shoot));
    bcd_top #(.CNT_W(16)) dut (.ref_clk_in(clk), .rst_n_in(rst_n), .pos_sensor_a_in(sa),
        .pos_sensor_b_in(sb), .pos_sensor_c_in(sc), .fwd_in(fwd), .sel60_in(s60),
        .out_enable_in(en), .over_current_in(oc), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .upper_drive_a_out(ua),
        .upper_drive_b_out(ub), .upper_drive_c_out(uc), .lower_drive_a_out(la),
        .lower_drive_b_out(lb), .lower_drive_c_out(lc), .osc_strobe_out(stb));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    // Expected on-flags {upper, lower} for a code; step tables by code 7 to 0
    function automatic logic [5:0] exp_drv(input logic [2:0] c, input logic m, input logic f);
        logic [23:0] t;
        logic [2:0] s;
        t = m ? 24'h4787E5 : 24'hE686A7;
        s = t[c * 3 +: 3];
        if (s == 3'h7) return 6'h00;
        return f ? {UP_T[s * 3 +: 3], LO_T[s * 3 +: 3]} : {LO_T[s * 3 +: 3], UP_T[s * 3 +: 3]};
    endfunction
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic cmp_reg(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic cmp_drv(input logic [5:0] g, input logic [5:0] e);
        cmp_reg({10'h000, g}, {10'h000, e});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Bounded wait for the oscillator strobe
    task automatic wait_stb(input int lim);
        for (int i = 0; i < lim; i++) begin
            tick(1);
            if (stb === 1'b1) return;
        end
        failures++;
        stop_test();
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        tick(3);
        rd_reg(2'h0, got);
        cmp_reg(got, 16'h0001);
        rd_reg(2'h1, got);
        cmp_reg(got, 16'h270F);
        rd_reg(2'h2, got);
        cmp_reg(got, 16'h1388);
        cmp_drv(drv, 6'h00);
        wait_stb(12000);
        tick(3);
        cmp_drv(drv, exp_drv(code, s60, fwd));
        wr_reg(2'h1, 16'h0014); // Short cycle for run time
        wr_reg(2'h2, 16'hFFFF);
        // Every code in both phasings and directions
        for (int k = 0; k < 32; k++) begin
            @(posedge clk);
            code <= k[2:0];
            s60 <= k[3];
            fwd <= k[4];
            tick(3);
            cmp_drv(drv, exp_drv(k[2:0], k[3], k[4]));
            rd_reg(2'h3, got);
            cmp_reg(got & 16'h000F, {12'h000, exp_drv(k[2:0], k[3], k[4]) != 6'h00, k[2:0]});
        end
        for (int k = 0; k < 40; k++) begin
            seed = xs(seed);
            @(posedge clk);
            code <= seed[2:0];
            s60 <= seed[3];
            fwd <= seed[4];
            en <= seed[5] | seed[6];
            tick(3);
            cmp_drv(drv, en ? exp_drv(code, s60, fwd) : 6'h00);
        end
        @(posedge clk);
        en <= 1'b1;
        code <= 3'h4;
        // Pulse width at both ends and at random
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            dv = (k == 0) ? 16'h0000 : (k == 1) ? 16'h0013 : {11'h000, seed[4:0] % 5'h14};
            wr_reg(2'h2, dv);
            wait_stb(64);
            wait_stb(64);
            cnt_u = 0;
            cnt_l = 0;
            for (int j = 0; j < 21; j++) begin
                cnt_u += (drv[5:3] != 3'h0);
                cnt_l += (drv[2:0] != 3'h0);
                tick(1);
            end
            cmp_reg(cnt_l[15:0], dv + 16'h0001);
            cmp_reg(cnt_u[15:0], 16'h0015);
        end
        wr_reg(2'h2, 16'hFFFF);
        wait_stb(64);
        wait_stb(64);
        repeat (4) @(posedge clk);
        oc <= 1'b1;
        @(posedge clk);
        oc <= 1'b0;
        tick(3);
        cmp_drv(drv, 6'h00);
        tick(8);
        cmp_drv(drv, 6'h00);
        wait_stb(64);
        tick(3);
        cmp_drv(drv, exp_drv(3'h4, s60, fwd));
        rd_reg(2'h3, got);
        cmp_reg(got & 16'h0040, 16'h0040);
        wr_reg(2'h3, 16'h0040);
        rd_reg(2'h3, got);
        cmp_reg(got & 16'h0040, 16'h0000);
        // Run allow bit cleared stops every drive, set again resumes
        wr_reg(2'h0, 16'h0000);
        tick(3);
        cmp_drv(drv, 6'h00);
        wr_reg(2'h0, 16'h0001);
        tick(3);
        cmp_drv(drv, exp_drv(3'h4, s60, fwd));
        cmp_reg({15'h0000, shoot}, 16'h0000);
        stop_test();
    end
endmodule
`default_nettype wire
